// file: hdl/pwesk_pkg.sv
// constants and register map of the pwm edge skew configuration block
package pwesk_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_SKEW_GROUP_3   = 8'h6B;
   localparam logic [7:0] ADDR_SKEW_GROUP_4   = 8'h6C;
   localparam logic [7:0] ADDR_SKEW_STATUS    = 8'h70;
   localparam logic [7:0] ADDR_ACTIVE_GROUP_3 = 8'h71;
   localparam logic [7:0] ADDR_ACTIVE_GROUP_4 = 8'h72;
   localparam logic [7:0] ADDR_APPLY_COUNT    = 8'h73;

   // ------------------------------------------------------------------
   // field layout of a skew group register
   // ------------------------------------------------------------------
   localparam int HI_POL_BIT  = 7;
   localparam int HI_CODE_MSB = 6;
   localparam int HI_CODE_LSB = 4;
   localparam int LO_POL_BIT  = 3;
   localparam int LO_CODE_MSB = 2;
   localparam int LO_CODE_LSB = 0;

   // status register fields
   localparam int STAT_PEND_BIT = 0;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_SKEW_GROUP = 8'h00;
   localparam logic [7:0] RST_APPLY_CNT  = 8'h00;
   localparam logic [7:0] RD_UNMAPPED    = 8'h00;

   // ------------------------------------------------------------------
   // polarity encoding
   // ------------------------------------------------------------------
   localparam logic POL_POSITIVE = 1'b0;
   localparam logic POL_NEGATIVE = 1'b1;

   // ------------------------------------------------------------------
   // timing of one offset step
   // ------------------------------------------------------------------
   localparam int STEP_NS       = 5;
   localparam int MAX_OFFSET_NS = 35;
   localparam int CODE_W        = 3;
   localparam int SKEW_NS_W     = 7;

   // edge index inside the skew vector
   localparam int EDGE_FIVE  = 0;
   localparam int EDGE_SIX   = 1;
   localparam int EDGE_SEVEN = 2;
   localparam int EDGE_EIGHT = 3;
   localparam int NUM_EDGES  = 4;

   typedef enum logic [1:0] {
      PWESK_IDLE,
      PWESK_PENDING
   } pwesk_state_t;

endpackage

// file: hdl/pwesk_top.sv
// pwm edge skew registers for edges five to eight, period aligned
//
// Operation
// - polarity 0 shifts later, 1 earlier
// - edge five: group 3 bits 6:4, bit 7
// - edges six, eight: bits 2:0, bit 3
// - edge seven: group 4 bits 6:4, bit 7
`timescale 1ns/1ps

module pwesk_top #(
   parameter int          ADDR_W  = 8,
   parameter int          DATA_W  = 8,
   parameter logic [7:0]  RST_VAL = pwesk_pkg::RST_SKEW_GROUP
) (
   input  wire logic               clock_i,
   input  wire logic               sys_rst_i,
   // register port
   input  wire logic [ADDR_W-1:0]  reg_addr_i,
   input  wire logic [DATA_W-1:0]  reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [DATA_W-1:0]  reg_rdata_o,
   // from the nominal timing logic
   input  wire logic               period_start_i,
   // applied settings per edge
   output logic                    apply_o,
   output logic                    edge_five_pol_o,
   output logic      [2:0]         edge_five_code_o,
   output logic signed [6:0]       edge_five_skew_ns_o,
   output logic                    edge_six_pol_o,
   output logic      [2:0]         edge_six_code_o,
   output logic signed [6:0]       edge_six_skew_ns_o,
   output logic                    edge_seven_pol_o,
   output logic      [2:0]         edge_seven_code_o,
   output logic signed [6:0]       edge_seven_skew_ns_o,
   output logic                    edge_eight_pol_o,
   output logic      [2:0]         edge_eight_code_o,
   output logic signed [6:0]       edge_eight_skew_ns_o
);

   // ------------------------------------------------------------------
   // local types and helpers
   // ------------------------------------------------------------------
   localparam int NE = pwesk_pkg::NUM_EDGES;
   localparam int CW = pwesk_pkg::CODE_W;
   localparam int SW = pwesk_pkg::SKEW_NS_W;

   // signed skew in ns from polarity and step code
   function automatic logic signed [SW-1:0] skew_ns(
      input logic          pol,
      input logic [CW-1:0] code
   );
      logic signed [SW-1:0] mag;
      mag = SW'(code) * SW'(pwesk_pkg::STEP_NS);
      if (pol == pwesk_pkg::POL_NEGATIVE) begin
         skew_ns = -mag;
      end else begin
         skew_ns = mag;
      end
   endfunction

   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [7:0]        target
   );
      addr_hit = (addr == ADDR_W'(target));
   endfunction

   // ------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------
   logic wr_grp3;
   logic wr_grp4;
   logic any_skew_wr;

   assign wr_grp3 = reg_wr_i &
                    addr_hit(reg_addr_i, pwesk_pkg::ADDR_SKEW_GROUP_3);
   assign wr_grp4 = reg_wr_i &
                    addr_hit(reg_addr_i, pwesk_pkg::ADDR_SKEW_GROUP_4);
   assign any_skew_wr = wr_grp3 | wr_grp4;

   // ------------------------------------------------------------------
   // software visible skew registers
   // ------------------------------------------------------------------
   logic [7:0] grp3_r;
   logic [7:0] grp4_r;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         grp3_r <= RST_VAL;
      end else if (wr_grp3) begin
         grp3_r <= reg_wdata_i[7:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         grp4_r <= RST_VAL;
      end else if (wr_grp4) begin
         grp4_r <= reg_wdata_i[7:0];
      end
   end

   // ------------------------------------------------------------------
   // update tracking
   // ------------------------------------------------------------------
   pwesk_pkg::pwesk_state_t state_r;
   pwesk_pkg::pwesk_state_t state_nxt;
   logic                    apply_r;

   // a write in the cycle of a period start stays pending
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pwesk_pkg::PWESK_IDLE: begin
            if (any_skew_wr) begin
               state_nxt = pwesk_pkg::PWESK_PENDING;
            end
         end
         pwesk_pkg::PWESK_PENDING: begin
            if (period_start_i && !any_skew_wr) begin
               state_nxt = pwesk_pkg::PWESK_IDLE;
            end
         end
         default: begin
            state_nxt = pwesk_pkg::PWESK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_r <= pwesk_pkg::PWESK_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   logic pending;
   logic do_apply;

   assign pending  = (state_r == pwesk_pkg::PWESK_PENDING);
   assign do_apply = pending & period_start_i;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         apply_r <= 1'b0;
      end else begin
         apply_r <= do_apply;
      end
   end

   // ------------------------------------------------------------------
   // active copies, loaded only at a period start
   // ------------------------------------------------------------------
   logic [7:0] act3_r;
   logic [7:0] act4_r;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         act3_r <= RST_VAL;
         act4_r <= RST_VAL;
      end else if (do_apply) begin
         act3_r <= grp3_r;
         act4_r <= grp4_r;
      end
   end

   logic [7:0] apply_cnt_r;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         apply_cnt_r <= pwesk_pkg::RST_APPLY_CNT;
      end else if (do_apply) begin
         apply_cnt_r <= apply_cnt_r + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // field split per edge
   // ------------------------------------------------------------------
   logic [NE-1:0] edge_pol;
   logic [CW-1:0] edge_code [NE];

   assign edge_pol[pwesk_pkg::EDGE_FIVE] =
      act3_r[pwesk_pkg::HI_POL_BIT];
   assign edge_code[pwesk_pkg::EDGE_FIVE] =
      act3_r[pwesk_pkg::HI_CODE_MSB:pwesk_pkg::HI_CODE_LSB];
   assign edge_pol[pwesk_pkg::EDGE_SIX] =
      act3_r[pwesk_pkg::LO_POL_BIT];
   assign edge_code[pwesk_pkg::EDGE_SIX] =
      act3_r[pwesk_pkg::LO_CODE_MSB:pwesk_pkg::LO_CODE_LSB];
   assign edge_pol[pwesk_pkg::EDGE_SEVEN] =
      act4_r[pwesk_pkg::HI_POL_BIT];
   assign edge_code[pwesk_pkg::EDGE_SEVEN] =
      act4_r[pwesk_pkg::HI_CODE_MSB:pwesk_pkg::HI_CODE_LSB];
   assign edge_pol[pwesk_pkg::EDGE_EIGHT] =
      act4_r[pwesk_pkg::LO_POL_BIT];
   assign edge_code[pwesk_pkg::EDGE_EIGHT] =
      act4_r[pwesk_pkg::LO_CODE_MSB:pwesk_pkg::LO_CODE_LSB];

   // ------------------------------------------------------------------
   // signed skew per edge, registered
   // ------------------------------------------------------------------
   logic signed [SW-1:0] skew_r [NE];

   generate
      for (genvar g = 0; g < NE; g++) begin : g_edge
         always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
               skew_r[g] <= '0;
            end else begin
               skew_r[g] <= skew_ns(edge_pol[g], edge_code[g]);
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // read port, data one cycle after the strobe
   // ------------------------------------------------------------------
   logic [7:0] rd_nxt;
   logic [7:0] rdata_r;

   always_comb begin
      rd_nxt = pwesk_pkg::RD_UNMAPPED;
      if (addr_hit(reg_addr_i, pwesk_pkg::ADDR_SKEW_GROUP_3)) begin
         rd_nxt = grp3_r;
      end else if (addr_hit(reg_addr_i,
                            pwesk_pkg::ADDR_SKEW_GROUP_4)) begin
         rd_nxt = grp4_r;
      end else if (addr_hit(reg_addr_i,
                            pwesk_pkg::ADDR_SKEW_STATUS)) begin
         rd_nxt[pwesk_pkg::STAT_PEND_BIT] = pending;
      end else if (addr_hit(reg_addr_i,
                            pwesk_pkg::ADDR_ACTIVE_GROUP_3)) begin
         rd_nxt = act3_r;
      end else if (addr_hit(reg_addr_i,
                            pwesk_pkg::ADDR_ACTIVE_GROUP_4)) begin
         rd_nxt = act4_r;
      end else if (addr_hit(reg_addr_i,
                            pwesk_pkg::ADDR_APPLY_COUNT)) begin
         rd_nxt = apply_cnt_r;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rdata_r <= pwesk_pkg::RD_UNMAPPED;
      end else if (reg_rd_i) begin
         rdata_r <= rd_nxt;
      end else begin
         rdata_r <= pwesk_pkg::RD_UNMAPPED;
      end
   end

   assign reg_rdata_o = DATA_W'(rdata_r);

   // ------------------------------------------------------------------
   // outputs toward the edge timing logic
   // ------------------------------------------------------------------
   assign apply_o = apply_r;

   assign edge_five_pol_o      = edge_pol[pwesk_pkg::EDGE_FIVE];
   assign edge_five_code_o     = edge_code[pwesk_pkg::EDGE_FIVE];
   assign edge_five_skew_ns_o  = skew_r[pwesk_pkg::EDGE_FIVE];

   assign edge_six_pol_o       = edge_pol[pwesk_pkg::EDGE_SIX];
   assign edge_six_code_o      = edge_code[pwesk_pkg::EDGE_SIX];
   assign edge_six_skew_ns_o   = skew_r[pwesk_pkg::EDGE_SIX];

   assign edge_seven_pol_o     = edge_pol[pwesk_pkg::EDGE_SEVEN];
   assign edge_seven_code_o    = edge_code[pwesk_pkg::EDGE_SEVEN];
   assign edge_seven_skew_ns_o = skew_r[pwesk_pkg::EDGE_SEVEN];

   assign edge_eight_pol_o     = edge_pol[pwesk_pkg::EDGE_EIGHT];
   assign edge_eight_code_o    = edge_code[pwesk_pkg::EDGE_EIGHT];
   assign edge_eight_skew_ns_o = skew_r[pwesk_pkg::EDGE_EIGHT];

endmodule // pwesk_top

// file: testbench/pwesk_chk_sva.sv
// assertion checker for the pwm edge skew block
`timescale 1ns/1ps
module pwesk_chk (
   input wire logic              clock_i,
   input wire logic              sys_rst_i,
   input wire logic [7:0]        reg_addr_i,
   input wire logic              reg_rd_i,
   input wire logic [7:0]        reg_rdata_o,
   input wire logic              period_start_i,
   input wire logic              apply_o,
   input wire logic              edge_five_pol_o,
   input wire logic [2:0]        edge_five_code_o,
   input wire logic signed [6:0] edge_five_skew_ns_o,
   input wire logic              edge_six_pol_o,
   input wire logic [2:0]        edge_six_code_o,
   input wire logic signed [6:0] edge_six_skew_ns_o,
   input wire logic              edge_seven_pol_o,
   input wire logic [2:0]        edge_seven_code_o,
   input wire logic signed [6:0] edge_seven_skew_ns_o,
   input wire logic              edge_eight_pol_o,
   input wire logic [2:0]        edge_eight_code_o,
   input wire logic signed [6:0] edge_eight_skew_ns_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire [15:0] act_w = {edge_five_pol_o, edge_five_code_o,
      edge_six_pol_o, edge_six_code_o, edge_seven_pol_o,
      edge_seven_code_o, edge_eight_pol_o, edge_eight_code_o};

   function automatic logic signed [6:0] ns_of(logic p, logic [2:0] c);
      ns_of = p ? -7'(c * 5) : 7'(c * 5);
   endfunction

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_five_skew: assert property (
      edge_five_skew_ns_o == ns_of($past(edge_five_pol_o),
      $past(edge_five_code_o))) else $error("edge five skew wrong");
   a_six_skew: assert property (
      edge_six_skew_ns_o == ns_of($past(edge_six_pol_o),
      $past(edge_six_code_o))) else $error("edge six skew wrong");
   a_seven_skew: assert property (
      edge_seven_skew_ns_o == ns_of($past(edge_seven_pol_o),
      $past(edge_seven_code_o))) else $error("edge seven skew wrong");
   a_eight_skew: assert property (
      edge_eight_skew_ns_o == ns_of($past(edge_eight_pol_o),
      $past(edge_eight_code_o))) else $error("edge eight skew wrong");
   a_hold_apply: assert property ($changed(act_w) |-> apply_o)
      else $error("edge setting moved without apply");
   a_apply_cause: assert property (apply_o |-> $past(period_start_i))
      else $error("apply without period start");
   a_apply_pulse: assert property (apply_o |=> !apply_o)
      else $error("apply longer than one cycle");
   a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside read slot");

   c_apply: cover property (apply_o);
   c_status: cover property (reg_rd_i && reg_addr_i == 8'h70);
   c_idle_start: cover property (period_start_i ##1 !apply_o);
endmodule // pwesk_chk

bind pwesk_top pwesk_chk u_chk (.clock_i, .sys_rst_i, .reg_addr_i,
   .reg_rd_i, .reg_rdata_o, .period_start_i, .apply_o, .edge_five_pol_o,
   .edge_five_code_o, .edge_five_skew_ns_o, .edge_six_pol_o,
   .edge_six_code_o, .edge_six_skew_ns_o, .edge_seven_pol_o,
   .edge_seven_code_o, .edge_seven_skew_ns_o, .edge_eight_pol_o,
   .edge_eight_code_o, .edge_eight_skew_ns_o);

// file: testbench/pwesk_gate_model.sv
// gate driver stand-in that latches applied edge skews
`timescale 1ns/1ps
module pwesk_gate_model (
   input  wire logic        clock_i,
   input  wire logic        apply_i,
   input  wire logic [27:0] skew_i,
   output logic      [27:0] held_o
);
   logic apply_r;
   // skews settle one cycle after the apply pulse
   always_ff @(posedge clock_i) begin
      apply_r <= apply_i;
      if (apply_r) begin
         held_o <= skew_i;
      end
   end
endmodule // pwesk_gate_model

// file: testbench/pwesk_top_tb.sv
// self-checking bench of the pwm edge skew block
`timescale 1ns/1ps
module pwesk_top_tb;
   logic              clock_i, sys_rst_i, reg_wr_i, reg_rd_i;
   logic              period_start_i, apply_o;
   logic [7:0]        reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [3:0]        pol;
   logic [2:0]        code [4];
   logic signed [6:0] ns [4];
   logic [27:0]       held;
   int                err_total = 0;
   int                check_count = 0;

   pwesk_top uut (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .period_start_i, .apply_o,
      .edge_five_pol_o(pol[0]), .edge_five_code_o(code[0]),
      .edge_five_skew_ns_o(ns[0]), .edge_six_pol_o(pol[1]),
      .edge_six_code_o(code[1]), .edge_six_skew_ns_o(ns[1]),
      .edge_seven_pol_o(pol[2]), .edge_seven_code_o(code[2]),
      .edge_seven_skew_ns_o(ns[2]), .edge_eight_pol_o(pol[3]),
      .edge_eight_code_o(code[3]), .edge_eight_skew_ns_o(ns[3]));
   pwesk_gate_model gate (.clock_i, .apply_i(apply_o),
      .skew_i({ns[3], ns[2], ns[1], ns[0]}), .held_o(held));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, d, input logic ps);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      period_start_i <= ps;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      period_start_i <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, exp);
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask

   // period start pulse, returns just after the taking edge
   task automatic pst;
      @(posedge clock_i);
      period_start_i <= 1'b1;
      @(posedge clock_i);
      period_start_i <= 1'b0;
      #1;
   endtask

   task automatic chk_act(input logic [7:0] g3, g4);
      logic [15:0] g;
      logic [3:0]  n;
      logic [6:0]  e;
      g = {g3, g4};
      chk({7'h00, apply_o}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         chk({4'h0, pol[i], code[i]}, {4'h0, g[15-4*i -: 4]});
      end
      repeat (2) @(posedge clock_i);
      #1;
      for (int i = 0; i < 4; i++) begin
         n = g[15-4*i -: 4];
         e = n[3] ? -7'(n[2:0] * 5) : 7'(n[2:0] * 5);
         chk({1'b0, ns[i]}, {1'b0, e});
         chk({1'b0, held[7*i +: 7]}, {1'b0, e});
      end
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      rdc(8'h6B, 8'h00);
      rdc(8'h6C, 8'h00);
      rdc(8'h70, 8'h00);
      rdc(8'h73, 8'h00);
      $display("reset values done");
   endtask

   task automatic t_sweep;
      logic [7:0] g3, g4;
      for (int c = 0; c < 8; c++) begin
         g3 = {c[0], c[2:0], ~c[0], ~c[2:0]};
         g4 = {~c[0], ~c[2:0], c[0], c[2:0]};
         wr(8'h6B, g3, 1'b0);
         wr(8'h6C, g4, 1'b0);
         rdc(8'h6B, g3);
         rdc(8'h70, 8'h01);
         pst;
         chk_act(g3, g4);
      end
      $display("code sweep done");
   endtask

   task automatic t_coinc;
      wr(8'h6B, 8'hA5, 1'b0);
      wr(8'h6C, 8'h3C, 1'b0);
      pst;
      chk_act(8'hA5, 8'h3C);
      wr(8'h6B, 8'h5A, 1'b1);
      #1;
      chk({pol[0], code[0], pol[1], code[1]}, 8'hA5);
      chk({7'h00, apply_o}, 8'h00);
      wr(8'h6C, 8'hC3, 1'b1);
      #1;
      chk_act(8'h5A, 8'h3C);
      rdc(8'h70, 8'h01);
      pst;
      chk_act(8'h5A, 8'hC3);
      $display("write at period start done");
   endtask

   task automatic t_refuse;
      wr(8'h70, 8'hFF, 1'b0);
      wr(8'h50, 8'hFF, 1'b0);
      rdc(8'h70, 8'h00);
      rdc(8'h50, 8'h00);
      rdc(8'h6B, 8'h5A);
      rdc(8'h6C, 8'hC3);
      pst;
      chk({7'h00, apply_o}, 8'h00);
      rdc(8'h71, 8'h5A);
      rdc(8'h72, 8'hC3);
      rdc(8'h73, 8'h0B);
      $display("refused accesses done");
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock_i);
      err_total++;
      stop_test;
   end

   initial begin
      sys_rst_i = 1'b1;
      {reg_wr_i, reg_rd_i, period_start_i} = 3'h0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_sweep;
      t_coinc;
      t_refuse;
      stop_test;
   end
endmodule // pwesk_top_tb
